// File: hw/ext_port_consts.vh
/*
 * Constants for the external bus port: bank decode, identity codes,
 * boot modes, DMA channel numbers and clock figures.
 * Assumes it is included by bare name from design files only.
 */
`ifndef EXT_PORT_CONSTS_VH
`define EXT_PORT_CONSTS_VH
`define BANK_MSB 25
`define BANK_LSB 24
`define ID_SINGLE 2'h0
`define ID_LINE1 2'h1
`define ID_LINE2 2'h2
`define DMA_CH_LINE1 4'h9
`define DMA_CH_LINE2 4'h8
`define BOOT_EPROM 2'h1
`define BOOT_HOST 2'h2
`define BOOT_NONE 2'h0
`define CORE_CLK_MULT 2
`define CLK_PERIOD_NS 40
`define STROBE_SETTLE 2'h2
`define CFG_READY_DRIVE_RST 1'h0
`endif

// File: hw/ext_bus_host_port_arbiter.v
/*
 * External parallel bus port with host and peer arbitration, wait-state
 * handling, bus float, external DMA request pairing and boot mode decode.
 * Assumes clk is the core clock (twice the input clock) and that a
 * testbench resolves two-way pins from the output enables (low = drive).
 */
`timescale 1ns/1ps
`include "ext_port_consts.vh"
module ext_bus_host_port_arbiter #(
  parameter AW = 26,
  parameter DW = 32,
  parameter SLAVE_WAITS = 2
) (
  input wire clk,
  input wire rstn,
  // Core access request side
  input wire reqValid,
  output reg reqReady,
  input wire [AW-1:0] reqAddr,
  input wire [DW-1:0] reqData,
  input wire reqWrite,
  input wire reqShort,
  input wire reqCondPass,
  input wire reqIsDma,
  output reg rspValid,
  input wire rspReady,
  output reg [DW-1:0] rspData,
  // External bus pins
  input wire [AW-3:0] addrIn,
  output reg [AW-3:0] addrOut,
  output reg addrOen,
  input wire [DW-1:0] dataIn,
  output reg [DW-1:0] dataOut,
  output reg dataOen,
  output reg [3:0] bankSelectN,
  input wire readStrobeInN,
  output reg readStrobeN,
  input wire storeStrobeInN,
  output reg storeStrobeN,
  input wire earlyWriteFlagInN,
  output reg earlyWriteFlagN,
  output reg strobeOen,
  input wire waitReleaseIn,
  output reg waitReleaseOut,
  output reg waitReleaseOen,
  input wire busFloatRequestN,
  input wire hostBusRequestN,
  output reg hostBusGrantN,
  input wire hostChipSelectN,
  output reg hostReadyOut,
  output reg hostReadyOen,
  input wire readyDriveModeBit,
  input wire [1:0] extDmaRequestN,
  output reg [1:0] extDmaGrantN,
  output reg [3:0] dmaChannel,
  input wire [1:0] peerBusRequestInN,
  output reg [1:0] peerBusRequestN,
  output reg [1:0] peerBusRequestOen,
  input wire corePriorityIn,
  input wire corePriorityReq,
  output reg corePriorityOen,
  input wire [1:0] identity,
  input wire eepromBootPin,
  input wire bootMemSelectIn,
  input wire hostWidthBit,
  output reg bootMemSelectOut,
  output reg bootMemSelectOen,
  output reg [1:0] bootMode,
  output reg hostBootWide,
  output reg slaveAccess,
  output reg slaveWrite,
  output reg [AW-3:0] slaveAddr,
  output reg [DW-1:0] slaveData,
  output reg busOwnerFlag
);
  localparam S_IDLE = 4'h1;
  localparam S_ADDR = 4'h2;
  localparam S_STRB = 4'h4;
  localparam S_DONE = 4'h8;
  // Two-stage synchronisers for the 13 strobe, request, wait and select pins; other inputs used raw
  reg [12:0] syncA;
  reg [12:0] syncB;
  wire [12:0] rawIn = {busFloatRequestN, hostBusRequestN, hostChipSelectN,
    extDmaRequestN, peerBusRequestInN, corePriorityIn, waitReleaseIn,
    readStrobeInN, storeStrobeInN, earlyWriteFlagInN, bootMemSelectIn};
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= 13'h1FFF;
      syncB <= 13'h1FFF;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end
  wire floatReq = ~syncB[12];
  wire hostReq = ~syncB[11];
  wire hostCs = ~syncB[10];
  wire [1:0] dmaReq = ~syncB[9:8];
  wire [1:0] peerReq = ~syncB[7:6];
  wire cpaActive = ~syncB[5];
  wire waitOk = syncB[4];
  wire slvRd = ~syncB[3];
  wire slvWr = ~syncB[2];
  wire slvEarly = ~syncB[1];
  wire bmsIn = syncB[0];
  // Identity latched after reset release; caught by clocked process
  reg [1:0] idReg;
  reg idTaken;
  reg [1:0] next_bootMode;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idReg <= `ID_SINGLE;
      idTaken <= 1'b0;
      bootMode <= `BOOT_NONE;
      hostBootWide <= 1'b0;
    end else if (!idTaken) begin
      idReg <= identity;
      idTaken <= 1'b1;
      bootMode <= next_bootMode;
      hostBootWide <= hostWidthBit;
    end
  end
  always @* begin
    if (eepromBootPin)
      next_bootMode = `BOOT_EPROM;
    else if (bmsIn)
      next_bootMode = `BOOT_HOST;
    else
      next_bootMode = `BOOT_NONE;
  end
  wire single = (idReg == `ID_SINGLE);
  wire ownLine = (idReg == `ID_LINE2);
  wire otherReq = ownLine ? peerReq[0] : peerReq[1];
  // Two-entry request buffer so a stall loses no word
  localparam BW = AW + DW + 4;
  reg [BW-1:0] buf0;
  reg [BW-1:0] buf1;
  reg [1:0] cnt;
  wire [BW-1:0] inWord = {reqAddr, reqData, reqWrite, reqShort, reqCondPass, reqIsDma};
  wire popReq;
  wire pushReq = reqValid & reqReady;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf0 <= {BW{1'b0}};
      buf1 <= {BW{1'b0}};
      cnt <= 2'h0;
      reqReady <= 1'b1;
    end else begin
      if (popReq) begin
        buf0 <= (cnt == 2'h2 || !pushReq) ? buf1 : inWord;
        if (pushReq && cnt == 2'h2)
          buf1 <= inWord;
      end else if (pushReq) begin
        if (cnt == 2'h0)
          buf0 <= inWord;
        else
          buf1 <= inWord;
      end
      cnt <= cnt + {1'b0, pushReq} - {1'b0, popReq};
      reqReady <= (cnt + {1'b0, pushReq} - {1'b0, popReq}) < 2'h2;
    end
  end
  wire haveReq = (cnt != 2'h0);
  wire [AW-1:0] hAddr = buf0[BW-1 -: AW];
  wire [DW-1:0] hData = buf0[DW+3:4];
  wire hWrite = buf0[3];
  wire hShort = buf0[2];
  wire hCond = buf0[1];
  wire hDma = buf0[0];
  // Mastership and access engine
  reg [3:0] state;
  reg master;
  reg hostGranted;
  reg ownReq;
  reg [1:0] strbCnt;
  wire busy = (state != S_IDLE);
  wire cpaBlock = hDma & cpaActive & master;
  wire wantBus = haveReq & ~cpaBlock;
  assign popReq = (state == S_DONE) & (~rspValid | rspReady);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      master <= 1'b0;
      hostGranted <= 1'b0;
      ownReq <= 1'b0;
      strbCnt <= 2'h0;
      rspValid <= 1'b0;
      rspData <= {DW{1'b0}};
    end else begin
      if (rspValid && rspReady)
        rspValid <= 1'b0;
      ownReq <= wantBus & ~single;
      if (hostReq && !busy && (master || single))
        hostGranted <= 1'b1;
      else if (!hostReq)
        hostGranted <= 1'b0;
      if (!busy) begin
        if (hostReq || (hostGranted && hostReq))
          master <= 1'b0;
        else if (single)
          master <= 1'b1;
        else if (ownReq && !(otherReq && ownLine))
          master <= 1'b1;
        else if (!ownReq)
          master <= master & ~otherReq;
      end
      case (state)
        S_IDLE: begin
          if (wantBus && master && !floatReq && !hostReq)
            state <= S_ADDR;
        end
        S_ADDR: begin
          strbCnt <= 2'h0;
          if (!floatReq)
            state <= S_STRB;
        end
        S_STRB: begin
          // Strobe lags a cycle and wait is synchronised: settle first
          strbCnt <= strbCnt + {1'b0, strbCnt != `STROBE_SETTLE};
          if (strbCnt == `STROBE_SETTLE && waitOk && !floatReq) begin
            state <= S_DONE;
            if (!hWrite)
              rspData <= hShort ? {{(DW-16){1'b0}}, dataIn[15:0]} : dataIn;
          end
        end
        S_DONE: begin
          if (!rspValid || rspReady) begin
            state <= S_IDLE;
            rspValid <= 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // Pin drivers, all registered
  wire driveBus = master & ~hostGranted & ~floatReq;
  wire active = (state == S_ADDR) | (state == S_STRB);
  wire [3:0] bankDec = ~(4'h1 << hAddr[`BANK_MSB:`BANK_LSB]);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrOut <= {(AW-2){1'b0}};
      addrOen <= 1'b1;
      dataOut <= {DW{1'b0}};
      dataOen <= 1'b1;
      bankSelectN <= 4'hF;
      readStrobeN <= 1'b1;
      storeStrobeN <= 1'b1;
      earlyWriteFlagN <= 1'b1;
      strobeOen <= 1'b1;
      hostBusGrantN <= 1'b1;
      busOwnerFlag <= 1'b0;
      peerBusRequestN <= 2'h3;
      peerBusRequestOen <= 2'h3;
      corePriorityOen <= 1'b1;
      extDmaGrantN <= 2'h3;
      dmaChannel <= 4'h0;
      bootMemSelectOut <= 1'b1;
      bootMemSelectOen <= 1'b1;
    end else begin
      addrOut <= hAddr[AW-3:0];
      addrOen <= ~driveBus;
      dataOut <= hShort ? {{(DW-16){1'b0}}, hData[15:0]} : hData;
      dataOen <= ~(driveBus & active & hWrite);
      strobeOen <= ~driveBus;
      // Conditional accesses still select the bank
      bankSelectN <= (active & driveBus) ? bankDec : 4'hF;
      readStrobeN <= ~((state == S_STRB) & ~hWrite);
      storeStrobeN <= ~((state == S_STRB) & hWrite & hCond);
      earlyWriteFlagN <= ~(active & hWrite);
      hostBusGrantN <= ~hostGranted;
      busOwnerFlag <= single | (master & ~hostGranted);
      peerBusRequestN <= ownLine ? {~ownReq, 1'b1} : {1'b1, ~ownReq};
      peerBusRequestOen <= single ? 2'h3 : (ownLine ? 2'h1 : 2'h2);
      corePriorityOen <= ~(corePriorityReq & ~master);
      extDmaGrantN <= ~(dmaReq & {2{master & ~busy}});
      dmaChannel <= dmaReq[0] ? `DMA_CH_LINE1 : (dmaReq[1] ? `DMA_CH_LINE2 : 4'h0);
      bootMemSelectOut <= ~((bootMode == `BOOT_EPROM) & active);
      bootMemSelectOen <= ~((bootMode == `BOOT_EPROM) & driveBus);
    end
  end
  // Slave side: peer or host reaching the io_processor_regs
  reg [1:0] waitCnt;
  wire slvSel = ~master & (slvRd | slvWr);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitCnt <= 2'h0;
      waitReleaseOut <= 1'b1;
      waitReleaseOen <= 1'b1;
      hostReadyOut <= 1'b1;
      hostReadyOen <= 1'b1;
      slaveAccess <= 1'b0;
      slaveWrite <= 1'b0;
      slaveAddr <= {(AW-2){1'b0}};
      slaveData <= {DW{1'b0}};
    end else begin
      slaveAccess <= slvSel & (waitCnt == 2'h0);
      slaveWrite <= slvEarly | slvWr;
      slaveAddr <= addrIn;
      slaveData <= dataIn;
      if (!slvSel)
        waitCnt <= SLAVE_WAITS[1:0];
      else if (waitCnt != 2'h0)
        waitCnt <= waitCnt - 2'h1;
      waitReleaseOut <= ~(slvSel & (waitCnt != 2'h0));
      waitReleaseOen <= ~slvSel;
      hostReadyOut <= ~(waitCnt != 2'h0);
      // Open-drain: only drive low unless active drive is set
      hostReadyOen <= ~(hostCs & hostReq &
        (readyDriveModeBit | (waitCnt != 2'h0)));
    end
  end
endmodule

// File: verif/ext_bus_host_port_arbiter_chk.sv
/* Port checker for the external bus arbiter.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
module ext_bus_host_port_arbiter_chk (
  input wire clk, input wire rstn, input wire addrOen, input wire dataOen,
  input wire strobeOen, input wire [3:0] bankSelectN, input wire busFloatRequestN,
  input wire hostBusRequestN, input wire hostBusGrantN, input wire hostChipSelectN,
  input wire hostReadyOen, input wire [1:0] peerBusRequestOen, input wire [1:0] identity,
  input wire busOwnerFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_floated;
    addrOen && dataOen && strobeOen;
  endsequence
  sequence s_single;
    identity == 2'h0 [*3];
  endsequence
  a_float_release: assert property ($fell(busFloatRequestN) |-> ##[1:3] s_floated)
    else $error("bus still driven under float request");
  a_grant_floats: assert property (!hostBusGrantN |-> s_floated)
    else $error("bus driven while host holds grant");
  a_grant_holds: assert property (!hostBusGrantN && !hostBusRequestN |=> !hostBusGrantN)
    else $error("grant dropped under host request");
  a_single_bank: assert property ($countones(~bankSelectN) <= 1)
    else $error("more than one bank selected");
  a_idle_banks: assert property (addrOen |-> bankSelectN == 4'hF)
    else $error("bank selected without bus access");
  a_ready_gated: assert property ((hostChipSelectN || hostBusRequestN) [*4] |-> hostReadyOen)
    else $error("ready driven without select and request");
  a_owner_single: assert property (s_single |-> busOwnerFlag)
    else $error("owner flag low in single mode");
  a_own_line: assert property (identity == 2'h1 |-> peerBusRequestOen[1])
    else $error("drives the other request line");
endmodule
bind ext_bus_host_port_arbiter ext_bus_host_port_arbiter_chk u_chk (.*);

// File: verif/ext_mem_model.sv
/* External memory on the far side of the port.
   Assumes active-low strobes sampled on the core clock. */
`timescale 1ns/1ps
module ext_mem_model (
  input wire clk,
  input wire [23:0] addrOut,
  input wire [31:0] dataOut,
  input wire readStrobeN,
  input wire storeStrobeN,
  output logic [31:0] dataIn,
  output logic waitReleaseIn
);
  logic [31:0] mem [0:15];
  logic [31:0] last = 32'h0;
  int waits = 0;
  int cnt = 0;
  always @(posedge clk) begin
    if (!storeStrobeN) mem[addrOut[3:0]] <= dataOut;
    if (!readStrobeN) last <= mem[addrOut[3:0]];
    cnt <= (readStrobeN && storeStrobeN) ? 0 : cnt + 1;
  end
  assign waitReleaseIn = (readStrobeN && storeStrobeN) || cnt >= waits;
  // Released bus shows the inverse of the last word so stale data never matches
  assign dataIn = !readStrobeN ? mem[addrOut[3:0]] : ~last;
endmodule

// File: verif/ext_bus_host_port_arbiter_tb.sv
/* Self-checking bench for the external bus arbiter.
   Assumes the memory model on the far side and a 25 MHz core clock. */
`timescale 1ns/1ps
module ext_bus_host_port_arbiter_tb;
  logic clk = 0, rstn = 0, reqValid = 0, reqWrite = 0, reqShort = 0, reqCondPass = 1;
  logic reqIsDma = 0, rspReady = 0, readStrobeInN = 1, storeStrobeInN = 1, peerReq = 1;
  logic earlyWriteFlagInN = 1, busFloatRequestN = 1, hostBusRequestN = 1, eepromBootPin = 0;
  logic hostChipSelectN = 1, readyDriveModeBit = 0, corePriorityReq = 0;
  logic bootMemSelectIn = 1, hostWidthBit = 1;
  logic [1:0] extDmaRequestN = 2'h3, identity = 2'h0;
  logic [25:0] reqAddr = 26'h0;
  logic [23:0] addrIn = 24'h0;
  logic [31:0] reqData = 32'h0;
  wire reqReady, rspValid, addrOen, dataOen, readStrobeN, storeStrobeN, earlyWriteFlagN;
  wire strobeOen, memWait, waitReleaseOut, waitReleaseOen, hostBusGrantN, hostReadyOut;
  wire hostReadyOen, corePriorityOen, bootMemSelectOut, bootMemSelectOen, hostBootWide;
  wire slaveAccess, slaveWrite, busOwnerFlag;
  wire [1:0] extDmaGrantN, peerBusRequestN, peerBusRequestOen, bootMode;
  wire [3:0] bankSelectN, dmaChannel;
  wire [23:0] addrOut, slaveAddr;
  wire [31:0] rspData, memData, dataOut, slaveData;
  wire corePriorityIn = corePriorityOen;
  wire waitReleaseIn = memWait & (waitReleaseOen | waitReleaseOut);
  wire [31:0] dataIn = dataOen ? memData : dataOut;
  wire [1:0] peerBusRequestInN = {peerReq & (peerBusRequestOen[1] | peerBusRequestN[1]),
                                  peerBusRequestOen[0] | peerBusRequestN[0]};
  int n_errors = 0, check_count = 0, i;
  ext_bus_host_port_arbiter u_dut (.*);
  ext_mem_model u_mem (.clk, .addrOut, .dataOut, .readStrobeN, .storeStrobeN,
    .dataIn(memData), .waitReleaseIn(memWait));
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] id, input logic boot);
    @(negedge clk);
    rstn = 0;
    identity = id;
    eepromBootPin = boot;
    repeat (6) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic access(input logic [25:0] a, input logic w, input logic sh,
      input logic [31:0] d, output logic [31:0] q, output logic [3:0] b);
    @(negedge clk);
    {reqValid, reqAddr, reqWrite, reqShort, reqData} = {1'b1, a, w, sh, d};
    for (i = 0; i < 50 && reqReady !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    reqValid = 0;
    rspReady = 1;
    b = 4'hF;
    for (i = 0; i < 300 && rspValid !== 1'b1; i++) begin
      @(negedge clk);
      if (bankSelectN !== 4'hF) b = bankSelectN;
    end
    chk("rspValid", rspValid, 1'b1);
    q = rspData;
    @(negedge clk);
    rspReady = 0;
  endtask
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
  initial begin
    logic [31:0] q;
    logic [3:0] b;
    do_reset(2'h0, 1'b0);
    chk("bootMode", {hostBootWide, bootMode}, 3'h6);
    chk("busOwnerFlag", busOwnerFlag, 1'b1);
    for (int k = 0; k < 4; k++) begin
      access({k[1:0], 20'h0, k[3:0]}, 1'b1, 1'b0, 32'hA5C30F00 + k, q, b);
      chk("bank", b, 4'(~(4'h1 << k)));
      u_mem.waits = k;
      access({k[1:0], 20'h0, k[3:0]}, 1'b0, 1'b0, 32'h0, q, b);
      chk("readData", q, 32'hA5C30F00 + k);
    end
    access(26'h0000005, 1'b1, 1'b1, 32'hFFFF1234, q, b);
    access(26'h0000005, 1'b0, 1'b1, 32'h0, q, b);
    chk("short", q, 32'h00001234);
    reqCondPass = 0;
    access(26'h1000003, 1'b1, 1'b0, 32'h0BAD0BAD, q, b);
    reqCondPass = 1;
    chk("condBank", b, 4'hD);
    chk("condMem", u_mem.mem[3], 32'hA5C30F03);
    busFloatRequestN = 0;
    fork
      access(26'h0000007, 1'b1, 1'b0, 32'h7, q, b);
      begin
        repeat (20) @(negedge clk);
        chk("floatStall", {rspValid, strobeOen}, 2'h1);
        busFloatRequestN = 1;
      end
    join
    chk("afterFloat", u_mem.mem[7], 32'h7);
    for (int k = 0; k < 2; k++) begin
      extDmaRequestN = k ? 2'h1 : 2'h2;
      for (i = 0; i < 50 && extDmaGrantN !== extDmaRequestN; i++) @(negedge clk);
      chk("dmaGrant", extDmaGrantN, k ? 2'h1 : 2'h2);
      chk("dmaChannel", dmaChannel, k ? 4'h8 : 4'h9);
      extDmaRequestN = 2'h3;
      repeat (10) @(negedge clk);
    end
    hostWidthBit = 0;
    do_reset(2'h1, 1'b1);
    chk("bootEprom", bootMode, 2'h1);
    // Win the bus first so this device is the one that grants the host
    access(26'h0000009, 1'b1, 1'b0, 32'h9, q, b);
    chk("ownLine", {busOwnerFlag, peerBusRequestOen}, 3'h6);
    {peerReq, hostBusRequestN, hostChipSelectN, readyDriveModeBit, corePriorityReq} = 5'h3;
    for (i = 0; i < 50 && hostBusGrantN !== 1'b0; i++) @(negedge clk);
    chk("grant", hostBusGrantN, 1'b0);
    repeat (30) @(negedge clk);
    chk("grantHeld", {hostBusGrantN, busOwnerFlag}, 2'h0);
    {peerReq, hostBusRequestN, hostChipSelectN} = 3'h7;
    for (i = 0; i < 50 && hostBusGrantN !== 1'b1; i++) @(negedge clk);
    chk("grantFree", hostBusGrantN, 1'b1);
    addrIn = 24'h000123;
    readStrobeInN = 0;
    for (i = 0; i < 50 && slaveAccess !== 1'b1; i++) @(negedge clk);
    chk("slaveRead", {slaveWrite, slaveAddr}, 25'h0000123);
    readStrobeInN = 1;
    repeat (10) @(negedge clk);
    final_report();
  end
endmodule
